// [logic/host_port_map.vh]
`ifndef HOST_PORT_MAP_VH
`define HOST_PORT_MAP_VH
`define HDR_ADAD_NI 8'h40
`define HDR_ADAD_IL 8'h48
`define HDR_CONST 8'h43
`define HDR_RD_WR_NI 8'h41
`define HDR_RD_WR_IL 8'h49
`define HDR_HALF_BIT 2
`define HDR_MASK 8'hFB
`define ADDR_RW_BIT 7
`define FIFO_TOP 8'h1F
`define FIFO_ALT_A 8'h6A
`define FIFO_ALT_B 8'h7A
`define MASK_ALL 8'hFF
`define MASK_RESET 8'hFF
`define RSS_LO 0
`define RSS_HI 1
`define RSS_RESET 2'h0
`define RSS_NONE 2'h0
`define RSS_RSVD 2'h1
`define RSS_CI_AWAKE 2'h2
`define RSS_WDOG 2'h3
`define CLK_MHZ 100
`define RST_PULSE_MIN_US 125
`define RST_PULSE_CYC (`RST_PULSE_MIN_US * `CLK_MHZ)
`define RST_CNT_W 15
`endif

// [logic/host_register_access_port.v]
// Summary of operation
// - Header 48h runs interleaved address-data sequences; read data overlaps input.
// - Header 43h FIFO addresses select current FIFO slot; pointer steps per byte.
// - Constant-address burst has any length and ends when chip select rises.
// - Header 41h reads address-data pairs, then a write address starts burst.
// - Header 49h reads interleaved, then a write address starts constant burst.
// - Latch pin high picks strobe style, low picks split strobes, edge muxed.
// - Any latch pin edge after the first cycle out of reset forces muxed style until hardware reset.
// - Muxed style latches the address off shared lines with the latch pin.
// - Scheme pin low is direct, high indirect with only address LSB decoded.
// - Request output stays active while any unmasked source is uncleared.
// - Top status holds seven summary bits of the interrupt sources.
// - A set mask bit stops its source from driving the request.
// - Mask all then restore gives a fresh request edge.
// - Reset field 10 selects command change and awake; 11 selects watchdog.
// - Reserved field 01 lets only the software reset drive the output.
// - Any internal reset event returns the reset field to its reset value.
// - Command change gives a reset pulse between 125 and 250 us.
// - Serial input sampled on rising clock, output on falling, MSB first.
// - Header bit 2 selects the lower or upper address half.
// - Request output active low after reset, may be set active high.
`timescale 1ns/1ns
`default_nettype none
`include "host_port_map.vh"
module host_register_access_port (
  input wire ref_clk,
  input wire rst,
  input wire serial_mode,
  input wire sclk,
  input wire cs_n,
  input wire serial_in_line,
  output reg serial_out_line,
  input wire ale,
  input wire rd_n,
  input wire wr_n,
  input wire [7:0] addr_in,
  input wire addr_scheme_pin,
  input wire [7:0] shared_addr_data_bus_in,
  output reg [7:0] shared_addr_data_bus_out,
  output reg shared_addr_data_bus_oe_n,
  output reg reg_wr,
  output reg reg_rd,
  output reg [7:0] reg_addr,
  output reg [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  output reg fifo_access,
  output reg [1:0] bus_style,
  input wire dchan_hdlc_irq,
  input wire bchan_hdlc_irq,
  input wire monitor_irq,
  input wire cmd_ind_irq,
  input wire tran_irq,
  input wire sync_transfer_irq,
  input wire aux_misc_irq,
  input wire [6:0] irq_clear,
  input wire [7:0] mask_wdata,
  input wire mask_we,
  input wire irq_active_high,
  output reg [6:0] top_irq_status,
  output reg irq_out,
  input wire [1:0] reset_source_wdata,
  input wire reset_source_we,
  input wire [3:0] downstream_command_field,
  input wire subscriber_awake_in,
  input wire watchdog_expired,
  input wire soft_reset_reg,
  output reg [1:0] reset_source_sel,
  output reg reset_out_pin
);
  // ****************************************************************
  // Input synchronisers.
  // ****************************************************************
  reg [7:0] s1_reg, s2_reg, bus_s1_reg, bus_s2_reg, adr_s1_reg, adr_s2_reg;
  reg sclk_d_reg, cs_d_reg, ale_d_reg, rd_d_reg, wr_d_reg, aw_d_reg;
  wire sclk_s, cs_s, din_s, ale_s, rd_s, wr_s, addr_scheme_pin_s, aw_s;
  assign {aw_s, addr_scheme_pin_s, wr_s, rd_s, ale_s, din_s, cs_s, sclk_s} = s2_reg;
  always @(posedge ref_clk)
  begin
    s1_reg <= {subscriber_awake_in, addr_scheme_pin, wr_n, rd_n, ale,
      serial_in_line, cs_n, sclk};
    s2_reg <= s1_reg;
    bus_s1_reg <= shared_addr_data_bus_in;
    bus_s2_reg <= bus_s1_reg;
    adr_s1_reg <= addr_in;
    adr_s2_reg <= adr_s1_reg;
    sclk_d_reg <= sclk_s;
    cs_d_reg <= cs_s;
    ale_d_reg <= ale_s;
    rd_d_reg <= rd_s;
    wr_d_reg <= wr_s;
    aw_d_reg <= aw_s;
  end
  wire sclk_rise = sclk_s & ~sclk_d_reg;
  wire sclk_fall = ~sclk_s & sclk_d_reg;
  wire cs_rise = cs_s & ~cs_d_reg;
  wire ale_edge = ale_s ^ ale_d_reg;
  // ****************************************************************
  // Serial sequencer.
  // ****************************************************************
  localparam ST_HDR = 5'b00001;
  localparam ST_ADR = 5'b00010;
  localparam ST_DAT = 5'b00100;
  localparam ST_BURST = 5'b01000;
  localparam ST_IDLE = 5'b10000;
  reg [4:0] st_reg;
  reg [7:0] hdr_reg, sh_reg, cur_adr_reg, tx_reg;
  reg [2:0] bit_reg, txbit_reg;
  reg cur_rd_reg, tx_pend_reg;
  wire [7:0] byte_in = {sh_reg[6:0], din_s};
  wire byte_done = sclk_rise & ~cs_s & (bit_reg == 3'h7);
  wire [7:0] hdr_base = hdr_reg & `HDR_MASK;
  wire interleaved = (hdr_base == `HDR_ADAD_IL) | (hdr_base == `HDR_RD_WR_IL);
  wire [7:0] full_adr = {hdr_reg[`HDR_HALF_BIT], byte_in[6:0]};
  wire is_fifo = ({1'b0, cur_adr_reg[6:0]} <= `FIFO_TOP) |
    ({1'b0, cur_adr_reg[6:0]} == `FIFO_ALT_A) |
    ({1'b0, cur_adr_reg[6:0]} == `FIFO_ALT_B);
  wire ser_rd = serial_mode & byte_done & (st_reg == ST_ADR) &
    byte_in[`ADDR_RW_BIT];
  wire ser_wr = serial_mode & byte_done &
    ((st_reg == ST_DAT) | (st_reg == ST_BURST));
  always @(posedge ref_clk)
  begin
    if (rst | cs_rise)
    begin
      st_reg <= ST_HDR;
      bit_reg <= 3'h0;
      hdr_reg <= 8'h00;
      sh_reg <= 8'h00;
      cur_adr_reg <= 8'h00;
      cur_rd_reg <= 1'b0;
    end
    else if (sclk_rise & ~cs_s & serial_mode)
    begin
      sh_reg <= byte_in;
      bit_reg <= bit_reg + 3'h1;
      if (bit_reg == 3'h7)
      begin
        case (st_reg)
          ST_HDR:
          begin
            hdr_reg <= byte_in;
            st_reg <= ST_ADR;
          end
          ST_ADR:
          begin
            cur_adr_reg <= full_adr;
            cur_rd_reg <= byte_in[`ADDR_RW_BIT];
            if (hdr_base == `HDR_CONST)
              st_reg <= ST_BURST;
            else if (((hdr_base == `HDR_RD_WR_NI) |
              (hdr_base == `HDR_RD_WR_IL)) & ~byte_in[`ADDR_RW_BIT])
              st_reg <= ST_BURST;
            else if (byte_in[`ADDR_RW_BIT] & interleaved)
              st_reg <= ST_ADR;
            else
              st_reg <= ST_DAT;
          end
          ST_DAT:
            st_reg <= ST_ADR;
          ST_BURST:
            st_reg <= ST_BURST;
          default:
            st_reg <= ST_HDR;
        endcase
      end
    end
  end
  // Read data leaves on falling clock edges, MSB first.
  always @(posedge ref_clk)
  begin
    if (rst | cs_rise)
    begin
      tx_reg <= 8'h00;
      tx_pend_reg <= 1'b0;
      txbit_reg <= 3'h0;
      serial_out_line <= 1'b1;
    end
    else
    begin
      if (serial_mode & reg_rd)
      begin
        tx_reg <= reg_rdata;
        tx_pend_reg <= 1'b1;
        txbit_reg <= 3'h0;
      end
      else if (sclk_fall & tx_pend_reg)
      begin
        serial_out_line <= tx_reg[3'h7 - txbit_reg];
        txbit_reg <= txbit_reg + 3'h1;
        if (txbit_reg == 3'h7)
          tx_pend_reg <= 1'b0;
      end
    end
  end
  // ****************************************************************
  // Parallel port.
  // ****************************************************************
  localparam [1:0] BUS_STROBE = 2'h0;
  localparam [1:0] BUS_SPLIT = 2'h1;
  localparam [1:0] BUS_MUX = 2'h2;
  reg [7:0] ind_adr_reg, mux_adr_reg;
  reg style_init_reg;
  wire strobe_style = (bus_style == BUS_STROBE);
  wire acc_on = strobe_style ? (~rd_s & ~cs_s) : (~cs_s & (~rd_s | ~wr_s));
  wire acc_prev = strobe_style ? (~rd_d_reg & ~cs_d_reg) :
    (~cs_d_reg & (~rd_d_reg | ~wr_d_reg));
  wire acc_start = ~serial_mode & acc_on & ~acc_prev;
  wire p_read = strobe_style ? wr_s : ~rd_s;
  wire [7:0] p_adr_raw = (bus_style == BUS_MUX) ? mux_adr_reg : adr_s2_reg;
  wire p_ind_data = addr_scheme_pin_s & p_adr_raw[0];
  wire [7:0] p_adr = addr_scheme_pin_s ? ind_adr_reg : p_adr_raw;
  wire p_adr_wr = addr_scheme_pin_s & ~p_adr_raw[0];
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      bus_style <= BUS_STROBE;
      style_init_reg <= 1'b1;
      ind_adr_reg <= 8'h00;
      mux_adr_reg <= 8'h00;
      shared_addr_data_bus_out <= 8'h00;
      shared_addr_data_bus_oe_n <= 1'b1;
    end
    else
    begin
      style_init_reg <= 1'b0;
      if (ale_edge & ~style_init_reg)
        bus_style <= BUS_MUX;
      else if (style_init_reg | bus_style != BUS_MUX)
        bus_style <= ale_s ? BUS_STROBE : BUS_SPLIT;
      if (bus_style == BUS_MUX & ale_s)
        mux_adr_reg <= bus_s2_reg;
      if (acc_start & ~p_read & p_adr_wr)
        ind_adr_reg <= bus_s2_reg;
      shared_addr_data_bus_oe_n <= ~(~serial_mode & acc_on & p_read);
      if (acc_start & p_read & p_adr_wr)
        shared_addr_data_bus_out <= ind_adr_reg;
      else if (~serial_mode & reg_rd)
        shared_addr_data_bus_out <= reg_rdata;
    end
  end
  // ****************************************************************
  // Register strobes toward the core.
  // ****************************************************************
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_addr <= 8'h00;
      reg_wdata <= 8'h00;
      fifo_access <= 1'b0;
    end
    else if (serial_mode)
    begin
      reg_rd <= ser_rd | (byte_done & st_reg == ST_BURST & cur_rd_reg);
      reg_wr <= ser_wr & ~cur_rd_reg;
      reg_addr <= (st_reg == ST_ADR) ? full_adr : cur_adr_reg;
      reg_wdata <= byte_in;
      fifo_access <= byte_done & (hdr_base == `HDR_CONST) &
        (st_reg == ST_BURST) & is_fifo;
    end
    else
    begin
      reg_rd <= acc_start & p_read & (~addr_scheme_pin_s | p_ind_data);
      reg_wr <= acc_start & ~p_read & (~addr_scheme_pin_s | p_ind_data);
      reg_addr <= p_adr;
      reg_wdata <= bus_s2_reg;
      fifo_access <= 1'b0;
    end
  end
  // ****************************************************************
  // Interrupt gathering.
  // ****************************************************************
  reg [7:0] mask_reg;
  wire [6:0] src = {dchan_hdlc_irq, bchan_hdlc_irq, monitor_irq,
    cmd_ind_irq, tran_irq, sync_transfer_irq, aux_misc_irq};
  wire [6:0] stat_next = src | (top_irq_status & ~irq_clear);
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      mask_reg <= `MASK_RESET;
      top_irq_status <= 7'h00;
      irq_out <= 1'b1;
    end
    else
    begin
      if (mask_we)
        mask_reg <= mask_wdata;
      top_irq_status <= stat_next;
      irq_out <= (|(stat_next & ~mask_reg[6:0])) ^ ~irq_active_high;
    end
  end
  // ****************************************************************
  // Reset source selection.
  // ****************************************************************
  reg [3:0] ci_d_reg;
  reg ci_init_reg;
  reg [`RST_CNT_W-1:0] rcnt_reg;
  localparam [31:0] RST_LOAD = `RST_PULSE_CYC;
  wire ci_chg = ~ci_init_reg & (downstream_command_field != ci_d_reg);
  wire aw_fall = ~aw_s & aw_d_reg;
  wire ev_ci = (reset_source_sel == `RSS_CI_AWAKE) & (ci_chg | aw_fall);
  wire int_ev = ev_ci | ((reset_source_sel == `RSS_WDOG) & watchdog_expired);
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      ci_d_reg <= 4'h0;
      ci_init_reg <= 1'b1;
      rcnt_reg <= {`RST_CNT_W{1'b0}};
      reset_source_sel <= `RSS_RESET;
      reset_out_pin <= 1'b1;
    end
    else
    begin
      ci_d_reg <= downstream_command_field;
      ci_init_reg <= 1'b0;
      if (int_ev)
        rcnt_reg <= RST_LOAD[`RST_CNT_W-1:0];
      else if (rcnt_reg != {`RST_CNT_W{1'b0}})
        rcnt_reg <= rcnt_reg - 1'b1;
      if (int_ev)
        reset_source_sel <= `RSS_RESET;
      else if (reset_source_we)
        reset_source_sel <= reset_source_wdata;
      reset_out_pin <= ~(soft_reset_reg | int_ev |
        (rcnt_reg > 1));
    end
  end
endmodule // host_register_access_port
`default_nettype wire

// [testbench/host_port_monitor.sv]
`timescale 1ns/1ns
`default_nettype none
// ****
// Checker on the host port pins.
// ****
module host_port_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic ale,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [1:0] bus_style,
  input wire logic [6:0] irq_clear,
  input wire logic dchan_hdlc_irq,
  input wire logic [7:0] mask_wdata,
  input wire logic mask_we,
  input wire logic irq_active_high,
  input wire logic [6:0] top_irq_status,
  input wire logic irq_out,
  input wire logic [3:0] downstream_command_field,
  input wire logic watchdog_expired,
  input wire logic soft_reset_reg,
  input wire logic [1:0] reset_source_sel,
  input wire logic reset_out_pin
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [15:0] low_cnt;
  logic sw_seen;
  // Counts the length of each low phase of the reset output.
  always_ff @(posedge ref_clk)
  begin
    if (rst || reset_out_pin)
    begin
      low_cnt <= 16'h0000;
      sw_seen <= 1'b0;
    end
    else
    begin
      low_cnt <= low_cnt + 16'h0001;
      sw_seen <= sw_seen | soft_reset_reg;
    end
  end
  sequence s_quiet;
    (top_irq_status == 7'h00 && $stable(irq_active_high)) [*3];
  endsequence
  sequence s_mask_all;
    mask_we && mask_wdata == 8'hFF ##1 !mask_we [*3];
  endsequence
  property p_idle_irq;
    s_quiet |-> irq_out == !irq_active_high;
  endproperty
  property p_mask_all;
    s_mask_all |-> irq_out == !irq_active_high;
  endproperty
  property p_clear;
    irq_clear[6] && !dchan_hdlc_irq |-> ##[1:2] !top_irq_status[6];
  endproperty
  property p_set;
    dchan_hdlc_irq |-> ##[1:2] top_irq_status[6];
  endproperty
  property p_style_keep;
    bus_style == 2'h2 |=> bus_style == 2'h2;
  endproperty
  property p_ale_edge;
    $changed(ale) |-> ##[1:6] bus_style == 2'h2;
  endproperty
  property p_ci_pulse;
    reset_source_sel == 2'h2 && $changed(downstream_command_field)
      |-> ##[1:4] !reset_out_pin;
  endproperty
  property p_pulse_len;
    $rose(reset_out_pin) && !sw_seen
      |-> low_cnt >= 16'h30D4 && low_cnt <= 16'h61A8;
  endproperty
  property p_rsvd;
    reset_source_sel == 2'h1 && watchdog_expired && !soft_reset_reg
      && reset_out_pin |=> reset_out_pin [*3];
  endproperty
  property p_evt_clears;
    $fell(reset_out_pin) && !soft_reset_reg && !$past(soft_reset_reg)
      |-> ##[0:3] reset_source_sel == 2'h0;
  endproperty
  property p_cs_idle;
    cs_n [*8] |-> !reg_wr && !reg_rd;
  endproperty
  a_idle_irq: assert property (p_idle_irq)
    else $error("request active with no source");
  a_mask_all: assert property (p_mask_all)
    else $error("request active while all masked");
  a_clear: assert property (p_clear)
    else $error("status bit not cleared");
  a_set: assert property (p_set)
    else $error("status bit not set");
  a_style_keep: assert property (p_style_keep)
    else $error("left multiplexed style");
  a_ale_edge: assert property (p_ale_edge)
    else $error("latch edge did not select multiplexed style");
  a_ci_pulse: assert property (p_ci_pulse)
    else $error("no reset pulse on command change");
  a_pulse_len: assert property (p_pulse_len)
    else $error("reset pulse length out of range");
  a_rsvd: assert property (p_rsvd)
    else $error("reserved setting let watchdog through");
  a_evt_clears: assert property (p_evt_clears)
    else $error("reset field not returned to reset value");
  a_cs_idle: assert property (p_cs_idle)
    else $error("access while chip select high");
endmodule // host_port_monitor
bind host_register_access_port host_port_monitor i_mon (.*);
`default_nettype wire

// [testbench/serial_host.sv]
`timescale 1ns/1ns
`default_nettype none
// ****
// Host controller on the serial link.
// ****
module serial_host (
  output logic sclk,
  output logic cs_n,
  output logic serial_in_line,
  input wire logic serial_out_line
);
  initial
  begin
    sclk = 1'b1;
    cs_n = 1'b1;
    serial_in_line = 1'b1;
  end
  // Drives chip select alone for parallel accesses.
  task automatic sel(input logic v);
    cs_n = v;
  endtask
  // Sends nb bits MSB first on separate in and out lines.
  task automatic xfer(input logic [7:0] tx, input int nb,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nb; i--)
    begin
      sclk = 1'b0;
      serial_in_line = tx[i];
      #40 sclk = 1'b1;
      #39 rx[i] = serial_out_line;
      #1;
    end
  endtask
  // Frames bytes with chip select; the last byte may be cut short.
  task automatic frame(input logic [7:0] b [$], input int nb,
                       output logic [7:0] r [$]);
    logic [7:0] x;
    r = {};
    #3 cs_n = 1'b0;
    #40;
    foreach (b[k])
    begin
      xfer(b[k], (k == b.size() - 1) ? nb : 8, x);
      r.push_back(x);
    end
    #20 cs_n = 1'b1;
    serial_in_line = ~serial_in_line;
    #300;
  endtask
endmodule // serial_host
`default_nettype wire

// [testbench/host_register_access_port_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module host_register_access_port_tb;
  logic ref_clk = 1'b0, rst = 1'b1, serial_mode = 1'b1, ale = 1'b1;
  logic sclk, cs_n, serial_in_line, serial_out_line, rd_n = 1'b1;
  logic wr_n = 1'b1, addr_scheme_pin = 1'b0, shared_addr_data_bus_oe_n;
  logic [7:0] addr_in = 8'hFF, shared_addr_data_bus_in = 8'hFF;
  logic [7:0] shared_addr_data_bus_out, reg_addr, reg_wdata, reg_rdata;
  logic [7:0] mask_wdata = 8'hFF, v;
  logic reg_wr, reg_rd, fifo_access, mask_we = 1'b0, irq_out;
  logic irq_active_high = 1'b0, reset_source_we = 1'b0, reset_out_pin;
  logic [1:0] bus_style, reset_source_wdata = 2'h0, reset_source_sel;
  logic [6:0] src = 7'h00, irq_clear = 7'h00, top_irq_status;
  logic subscriber_awake_in = 1'b1, watchdog_expired = 1'b0;
  logic soft_reset_reg = 1'b0;
  logic [7:0] pq;
  logic poe;
  logic [3:0] downstream_command_field = 4'h0;
  logic dchan_hdlc_irq, bchan_hdlc_irq, monitor_irq, cmd_ind_irq;
  logic tran_irq, sync_transfer_irq, aux_misc_irq;
  logic [15:0] wq [$], eq [$];
  logic [7:0] bq [$], rq [$];
  int n_errors = 0, samples_checked = 0, seed = 11, cyc = 0, fifo_n = 0;
  int n;
  assign {dchan_hdlc_irq, bchan_hdlc_irq, monitor_irq, cmd_ind_irq,
          tran_irq, sync_transfer_irq, aux_misc_irq} = src;
  assign reg_rdata = reg_addr ^ 8'h5A;
  always #5 ref_clk = ~ref_clk;
  host_register_access_port i_host_register_access_port (.*);
  serial_host u_host (.*);
  always @(posedge ref_clk)
  begin
    cyc++;
    if (reg_wr)
      wq.push_back({reg_addr, reg_wdata});
    if (fifo_access)
      fifo_n++;
    if (cyc == 95000)
    begin
      n_errors++;
      $display("MISMATCH %0t timeout", $time);
      close_out;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task go(input int c);
    repeat (c) @(negedge ref_clk);
  endtask
  task do_rst;
    rst = 1'b1;
    go(6);
    rst = 1'b0;
    go(4);
  endtask
  // Runs one frame and compares the write log with the model.
  task sfr(input int nb);
    u_host.frame(bq, nb, rq);
    go(8);
    chk(wq.size(), eq.size());
    foreach (eq[i])
      chk(wq[i], eq[i]);
    wq = {};
  endtask
  // Runs one parallel access and keeps the bus output seen near its end.
  task pacc(input logic w, input logic [7:0] a, input logic [7:0] d);
    addr_in = a;
    shared_addr_data_bus_in = d;
    u_host.sel(1'b0);
    wr_n = !w;
    rd_n = w;
    go(8);
    pq = shared_addr_data_bus_out;
    poe = shared_addr_data_bus_oe_n;
    wr_n = 1'b1;
    rd_n = 1'b1;
    u_host.sel(1'b1);
    go(6);
  endtask
  task wmask(input logic [7:0] m);
    mask_wdata = m;
    mask_we = 1'b1;
    go(1);
    mask_we = 1'b0;
    go(4);
  endtask
  task rsel(input logic [1:0] s);
    reset_source_wdata = s;
    reset_source_we = 1'b1;
    go(1);
    reset_source_we = 1'b0;
    go(1);
  endtask
  task pulse;
    n = 0;
    for (int t = 0; t < 20 && reset_out_pin === 1'b1; t++)
      go(1);
    while (reset_out_pin === 1'b0 && n < 30000)
    begin
      go(1);
      n++;
    end
    chk(n >= 12500 && n <= 25000, 1);
  endtask
  initial
  begin
    do_rst;
    chk(bus_style, 2'h0);
    ale = 1'b0;
    go(8);
    chk(bus_style, 2'h2);
    do_rst;
    chk(bus_style, 2'h1);
    $display("bus style done");
    bq = '{8'h48, 8'h05, 8'hA5, 8'h81, 8'h06, 8'h11};
    eq = '{16'h05A5, 16'h0611};
    sfr(8);
    chk(rq[4], 8'h01 ^ 8'h5A);
    bq = '{8'h4C, 8'h05, 8'h3C};
    eq = '{16'h853C};
    sfr(8);
    bq = '{8'h49, 8'h83, 8'h07, 8'h11, 8'h22};
    eq = '{16'h0711, 16'h0722};
    sfr(8);
    chk(rq[2], 8'h03 ^ 8'h5A);
    bq = '{8'h43, 8'h10, 8'hD1, 8'hD2, 8'hD3};
    eq = '{16'h10D1, 16'h10D2, 16'h10D3};
    sfr(8);
    chk(fifo_n, 3);
    bq = '{8'h48, 8'h05, 8'h99};
    eq = {};
    sfr(4);
    bq = '{8'h48, 8'h05, 8'h77};
    eq = '{16'h0577};
    sfr(8);
    $display("serial done");
    for (int p = 0; p < 2; p++)
    begin
      irq_active_high = p[0];
      wmask(8'h00);
      v = $random(seed) | 8'h01;
      addr_in = $random(seed);
      src = v[6:0];
      go(1);
      src = 7'h00;
      go(4);
      chk(top_irq_status, v[6:0]);
      chk(irq_out, p[0]);
      wmask(8'hFF);
      chk(irq_out, !p[0]);
      wmask(8'h00);
      chk(irq_out, p[0]);
      irq_clear = v[6:0];
      go(1);
      irq_clear = 7'h00;
      go(4);
      chk(top_irq_status, 7'h00);
      chk(irq_out, !p[0]);
    end
    $display("interrupt done");
    rsel(2'h2);
    downstream_command_field = 4'h5;
    pulse;
    chk(reset_source_sel, 2'h0);
    rsel(2'h2);
    subscriber_awake_in = 1'b0;
    pulse;
    subscriber_awake_in = 1'b1;
    rsel(2'h3);
    watchdog_expired = 1'b1;
    go(1);
    watchdog_expired = 1'b0;
    pulse;
    rsel(2'h1);
    watchdog_expired = 1'b1;
    downstream_command_field = 4'hA;
    go(1);
    watchdog_expired = 1'b0;
    go(10);
    chk(reset_out_pin, 1'b1);
    soft_reset_reg = 1'b1;
    go(5);
    chk(reset_out_pin, 1'b0);
    soft_reset_reg = 1'b0;
    for (int t = 0; t < 30000 && reset_out_pin !== 1'b1; t++)
      go(1);
    chk(reset_out_pin, 1'b1);
    $display("reset source done");
    serial_mode = 1'b0;
    wq = {};
    v = $random(seed);
    pacc(1'b1, 8'h25, v);
    chk(wq.size(), 1);
    chk(wq[0], {8'h25, v});
    pacc(1'b0, 8'h25, 8'hFF);
    chk(pq, 8'h25 ^ 8'h5A);
    chk(poe, 1'b0);
    addr_scheme_pin = 1'b1;
    pacc(1'b1, 8'hFE, 8'h33);
    pacc(1'b1, 8'hFF, v);
    chk(wq.size(), 2);
    chk(wq[1], {8'h33, v});
    pacc(1'b0, 8'hFE, 8'hFF);
    chk(pq, 8'h33);
    pacc(1'b0, 8'hFF, 8'hFF);
    chk(pq, 8'h33 ^ 8'h5A);
    addr_scheme_pin = 1'b0;
    shared_addr_data_bus_in = 8'h3C;
    ale = 1'b1;
    go(8);
    chk(bus_style, 2'h2);
    ale = 1'b0;
    pacc(1'b1, 8'hFF, v);
    chk(wq.size(), 3);
    chk(wq[2], {8'h3C, v});
    $display("parallel done");
    close_out;
  end
endmodule // host_register_access_port_tb
`default_nettype wire
